// File: tb/dma_req_handshake_tb.sv
/*
 * Self-checking bench of the request handshake block.
 * Assumes the peripheral and bus controller model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module dma_req_handshake_tb;
	typedef struct packed {
		logic [11:0] ctrl;
		logic [7:0] cnt;
		logic [7:0] want;
		logic [7:0] units;
		logic [7:0] minlat;
		logic slow;
		logic stop;
	} scen_s;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, load, slow, ack_q, data_ack_q, dual, ack_wr;
	logic [7:0] awaddr, araddr, load_n;
	logic [31:0] wdata, rdata, rd, left;
	logic [1:0] bresp, rresp, rs;
	logic xfer_request_n, request_ack, data_ack, transfer_end_irq;
	logic bus_cycle_req, bus_cycle_wr, bus_cycle_start, bus_cycle_end;
	int n_mismatch, comparisons, n_ack, n_data_ack, long_ack, wr_bad, lat, first_lat, k, i;
	scen_s sc;
	scen_s tab [0:9];

	dma_req_handshake #(.CNT_W(24)) dma_req_handshake_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .xfer_request_n(xfer_request_n),
		.request_ack(request_ack), .data_ack(data_ack), .transfer_end_irq(transfer_end_irq),
		.bus_cycle_req(bus_cycle_req), .bus_cycle_wr(bus_cycle_wr),
		.bus_cycle_start(bus_cycle_start), .bus_cycle_end(bus_cycle_end));
	periph_model periph_model_i (.aclk(aclk), .aresetn(aresetn), .load(load),
		.load_n(load_n), .slow(slow), .request_ack(request_ack),
		.xfer_request_n(xfer_request_n), .bus_cycle_req(bus_cycle_req),
		.bus_cycle_start(bus_cycle_start), .bus_cycle_end(bus_cycle_end));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Pin, ack and data ack watcher
	always @(posedge aclk) begin
		if (request_ack) n_ack++;
		if (request_ack && ack_q) long_ack++;
		if (data_ack && !data_ack_q) begin
			n_data_ack++;
			if (dual && bus_cycle_wr !== ack_wr) wr_bad++;
		end
		if (lat >= 0) begin
			lat++;
			if (bus_cycle_req && first_lat < 0) first_lat = lat;
		end else if (xfer_request_n === 1'b0) lat = 0;
		ack_q = request_ack;
		data_ack_q = data_ack;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic give_up(input string what);
		n_mismatch++;
		$display("MISMATCH %s expected answer seen timeout", what);
		results();
	endtask : give_up

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int j;
		logic aw_on, w_on;
		@(posedge aclk);
		aw_on = 1'b1;
		w_on = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (j = 0; j < 64; j++) begin
			@(posedge aclk);
			if (aw_on && awready) begin
				awvalid <= 1'b0;
				aw_on = 1'b0;
			end
			if (w_on && wready) begin
				wvalid <= 1'b0;
				w_on = 1'b0;
			end
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (j == 64) give_up("write response");
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int j;
		logic ar_on;
		@(posedge aclk);
		ar_on = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (j = 0; j < 64; j++) begin
			@(posedge aclk);
			if (ar_on && arready) begin
				arvalid <= 1'b0;
				ar_on = 1'b0;
			end
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (j == 64) give_up("read data");
	endtask : axi_read

	task automatic wait_idle;
		int j;
		for (j = 0; j < 200; j++) begin
			axi_read(dma_req_pkg::OFS_STAT, rd, rs);
			if ((rd & 32'h000000b7) == 32'h0) break;
		end
		if (j == 200) give_up("idle");
	endtask : wait_idle

	task automatic set_model(input logic [7:0] n, input logic s);
		@(posedge aclk);
		load <= 1'b1;
		load_n <= n;
		slow <= s;
		@(posedge aclk);
		load <= 1'b0;
	endtask : set_model

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, load, slow, ack_q, data_ack_q} = '0;
		{awaddr, araddr, load_n, wdata, dual, ack_wr} = '0;
		{n_mismatch, comparisons, n_ack, n_data_ack, long_ack, wr_bad} = '0;
		lat = -1;
		first_lat = -1;
		aresetn = 1'b0;
		// ctrl, count, units wanted, units done, least delay, slow, stop
		tab[0] = '{12'h005, 8'd2, 8'd2, 8'd2, 8'd4, 1'b1, 1'b0};
		tab[1] = '{12'h001, 8'd2, 8'd2, 8'd2, 8'd4, 1'b1, 1'b0};
		tab[2] = '{12'h019, 8'd1, 8'd1, 8'd1, 8'd5, 1'b0, 1'b0};
		tab[3] = '{12'h00d, 8'd1, 8'd1, 8'd1, 8'd5, 1'b0, 1'b0};
		tab[4] = '{12'h003, 8'd2, 8'd2, 8'd2, 8'd4, 1'b1, 1'b0};
		tab[5] = '{12'h047, 8'd2, 8'd2, 8'd2, 8'd6, 1'b1, 1'b0};
		tab[6] = '{12'h02b, 8'd3, 8'd1, 8'd3, 8'd5, 1'b0, 1'b0};
		tab[7] = '{12'h005, 8'd3, 8'd1, 8'd1, 8'd4, 1'b1, 1'b0};
		tab[8] = '{12'h005, 8'd6, 8'd6, 8'd0, 8'd4, 1'b1, 1'b1};
		tab[9] = '{12'h00f, 8'd6, 8'd1, 8'd0, 8'd5, 1'b0, 1'b1};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(dma_req_pkg::OFS_CTRL, rd, rs);
		chk("ctrl reset", dma_req_pkg::CTRL_RST, rd);
		axi_read(dma_req_pkg::OFS_COUNT, rd, rs);
		chk("count reset", dma_req_pkg::COUNT_RST, rd);
		axi_read(dma_req_pkg::OFS_OPER, rd, rs);
		chk("oper reset", dma_req_pkg::OPER_RST, rd);
		axi_read(8'h10, rd, rs);
		chk("unmapped read", {30'h0, dma_req_pkg::RESP_DECERR}, {rd[29:0], rs});
		axi_write(8'h10, 32'h1, rs);
		chk("unmapped write", {30'h0, dma_req_pkg::RESP_DECERR}, {30'h0, rs});
		axi_write(dma_req_pkg::OFS_OPER, 32'h1, rs);
		chk("mapped write", {30'h0, dma_req_pkg::RESP_OKAY}, {30'h0, rs});
		for (k = 0; k < 10; k++) begin
			sc = tab[k];
			dual = !sc.ctrl[2];
			ack_wr = sc.ctrl[4];
			axi_write(dma_req_pkg::OFS_COUNT, {24'h0, sc.cnt}, rs);
			axi_write(dma_req_pkg::OFS_CTRL, {20'h0, sc.ctrl}, rs);
			@(negedge aclk);
			{n_ack, n_data_ack, long_ack, wr_bad} = '0;
			lat = -1;
			first_lat = -1;
			set_model(sc.want, sc.slow);
			for (i = 0; i < 3000; i++) begin
				@(posedge aclk);
				if (n_data_ack >= (sc.stop ? 1 : int'(sc.units))) break;
			end
			if (i == 3000) give_up("transfer units");
			if (sc.stop) axi_write(dma_req_pkg::OFS_CTRL, {20'h0, sc.ctrl[11:1], 1'b0}, rs);
			wait_idle();
			left = 32'(sc.cnt) - 32'(n_data_ack);
			axi_read(dma_req_pkg::OFS_COUNT, rd, rs);
			chk("count left", left, rd);
			axi_read(dma_req_pkg::OFS_CTRL, rd, rs);
			chk("end flag", {31'h0, left == 0}, {31'h0, rd[dma_req_pkg::CTL_TE]});
			chk("irq", {31'h0, left == 0 && sc.ctrl[5]}, {31'h0, transfer_end_irq});
			chk("ack width", 32'h0, 32'(long_ack));
			chk("data ack phase", 32'h0, 32'(wr_bad));
			chk("start delay", 32'h1, {31'h0, first_lat >= int'(sc.minlat)});
			if (sc.ctrl[1] && sc.ctrl[3])
				chk("burst acks", 32'h1, 32'(n_ack));
			else
				chk("acks", 32'(n_data_ack), 32'(n_ack));
			if (sc.stop)
				chk("stopped early", 32'h1, {31'h0, n_data_ack < int'(sc.cnt)});
			else
				chk("units", 32'(sc.units), 32'(n_data_ack));
			axi_write(dma_req_pkg::OFS_CTRL, 32'h00000100, rs);
			set_model(8'h00, 1'b0);
		end
		results();
	end
endmodule : dma_req_handshake_tb
`default_nettype wire

// File: tb/periph_model.sv
/*
 * Model of the requesting peripheral and of the bus state controller.
 * Assumes the handshake's registered outputs and one bus clock.
 */
`timescale 1ns/1ps
`default_nettype none
module periph_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench control
	input wire logic load,
	input wire logic [7:0] load_n,
	input wire logic slow,
	// Request pin side
	input wire logic request_ack,
	output logic xfer_request_n,
	// Bus state controller side
	input wire logic bus_cycle_req,
	output logic bus_cycle_start,
	output logic bus_cycle_end
);
	logic [7:0] left_q;
	logic [2:0] wait_q;
	logic busy_q;
	logic [2:0] start_wait;
	assign start_wait = slow ? 3'h4 : 3'h1;
	assign xfer_request_n = (left_q == 8'h00);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			left_q <= 8'h00;
		else if (load)
			left_q <= load_n;
		else if (request_ack && left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end
	always_ff @(posedge aclk) begin
		bus_cycle_start <= 1'b0;
		bus_cycle_end <= 1'b0;
		if (!aresetn) begin
			busy_q <= 1'b0;
			wait_q <= 3'h0;
		end else if (!busy_q && bus_cycle_req) begin
			wait_q <= wait_q + 3'h1;
			if (wait_q == start_wait) begin
				bus_cycle_start <= 1'b1;
				busy_q <= 1'b1;
				wait_q <= 3'h0;
			end
		end else if (busy_q) begin
			wait_q <= wait_q + 3'h1;
			if (wait_q == 3'h2) begin
				bus_cycle_end <= 1'b1;
				busy_q <= 1'b0;
				wait_q <= 3'h0;
			end
		end
	end
endmodule : periph_model
`default_nettype wire

// File: verilog/dma_req_handshake.sv
/*
 * External request handshake of one DMA channel: request sampling, earliest
 * start, acknowledge outputs, staged stop and count end, with an AXI4-Lite
 * register slave.
 * Assumes a bus state controller on aclk that answers bus_cycle_req with
 * one-cycle bus_cycle_start and bus_cycle_end pulses.
 */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
//
// Summary of operation
// - Sample request pin every rising bus clock
// - First transfer no sooner than four cycles
// - Edge recognised two cycles, level one
// - Single level: resample after bus cycle start
// - Request ack pulses one cycle per detection
// - Burst edge samples and acknowledges once only
// - Burst edge: start after five, run count
// - Dual level: resample after write start
// - Dual edge: five cycles, resample read end
// - Single edge: five cycles, resample after ack
// - Burst dual level times like cycle steal
// - Single address: data ack every cycle
// - Dual: data ack read or write selectable
// - Block transfer starts no sooner than six
// - Negated level request gets no further ack
// - Stop: refuse new, finish accepted, halt
// - Burst edge stop sampled like requests
// - Count zero bypasses the staged stop
// - Bus cycle length set by bus controller
// - Count zero stops, sets end flag, irq
`timescale 1ns/1ps
`default_nettype none
module dma_req_handshake #(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral pins
	input wire logic xfer_request_n,
	output logic request_ack,
	output logic data_ack,
	output logic transfer_end_irq,
	// Bus state controller
	output logic bus_cycle_req,
	output logic bus_cycle_wr,
	input wire logic bus_cycle_start,
	input wire logic bus_cycle_end
);
	dma_req_pkg::state_e state_q, state_d;
	dma_req_pkg::cfg_s cfg;
	logic [31:0] ctrl_q, oper_q;
	logic [CNT_W-1:0] count_q;
	logic te_q;
	logic req_low, req_fall, req_seen;
	logic samp_q, arm_late, arm_now, detect;
	logic [1:0] pend_q;
	logic burst_run_q, ack_q, data_ack_q, cyc_on_q, breq_q;
	logic stop_req, unit_end, last_unit, continue_burst, go_wait, dly_done;
	logic [dma_req_pkg::DLY_W-1:0] dly_val;
	logic [2:0] since_det_q;

	// AXI write side
	logic aw_q, w_q, bvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write, wr_ctrl, wr_count, wr_oper, wr_hit;
	// AXI read side
	logic rvalid_q;
	logic [31:0] rdata_q, rd_mux;
	logic [1:0] rresp_q, bresp_q;
	logic rd_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign cfg = dma_req_pkg::cfg_s'(ctrl_q[dma_req_pkg::CFG_W-1:0]);

	// Register bus decode
	assign s_axi_awready = ~aw_q & ~bvalid_q;
	assign s_axi_wready = ~w_q & ~bvalid_q;
	assign do_write = aw_q & w_q & ~bvalid_q;
	assign wr_ctrl = do_write & (awaddr_q == dma_req_pkg::OFS_CTRL);
	assign wr_count = do_write & (awaddr_q == dma_req_pkg::OFS_COUNT);
	assign wr_oper = do_write & (awaddr_q == dma_req_pkg::OFS_OPER);
	assign wr_hit = wr_ctrl | wr_count | wr_oper | (awaddr_q == dma_req_pkg::OFS_STAT);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_comb begin
		rd_hit = 1'b1;
		if (s_axi_araddr == dma_req_pkg::OFS_CTRL) begin
			rd_mux = ctrl_q;
			rd_mux[dma_req_pkg::CTL_TE] = te_q;
		end else if (s_axi_araddr == dma_req_pkg::OFS_COUNT) begin
			rd_mux = 32'(count_q);
		end else if (s_axi_araddr == dma_req_pkg::OFS_OPER) begin
			rd_mux = oper_q;
		end else if (s_axi_araddr == dma_req_pkg::OFS_STAT) begin
			rd_mux = {24'h000000, burst_run_q, samp_q, pend_q, 1'b0, state_q};
		end else begin
			rd_mux = 32'h00000000;
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= dma_req_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? dma_req_pkg::RESP_OKAY : dma_req_pkg::RESP_DECERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= dma_req_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? dma_req_pkg::RESP_OKAY : dma_req_pkg::RESP_DECERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Control registers; the end flag is cleared by writing one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= dma_req_pkg::CTRL_RST;
			oper_q <= dma_req_pkg::OPER_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'(2 ** dma_req_pkg::CFG_W - 1);
			end
			if (wr_oper) begin
				oper_q <= merge(oper_q, wdata_q, wstrb_q) & 32'(1 << dma_req_pkg::OPR_ME);
			end
		end
	end

	// count and end flag, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= CNT_W'(dma_req_pkg::COUNT_RST);
			te_q <= 1'b0;
		end else begin
			if (unit_end) begin
				count_q <= count_q - CNT_W'(1);
			end else if (wr_count) begin
				count_q <= CNT_W'(merge(32'(count_q), wdata_q, wstrb_q));
			end
			if (unit_end && last_unit) begin
				te_q <= 1'b1;
			end else if (wr_ctrl && wstrb_q[1] && wdata_q[dma_req_pkg::CTL_TE]) begin
				te_q <= 1'b0;
			end
		end
	end
	assign transfer_end_irq = te_q & cfg.ie;

	// pin sampled on every rising bus clock edge
	req_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.xfer_request_n(xfer_request_n),
		.req_low(req_low),
		.req_fall(req_fall)
	);

	// disable of channel or master halts acceptance
	assign stop_req = ~cfg.enable | ~oper_q[dma_req_pkg::OPR_ME];
	assign req_seen = cfg.edge_det ? req_fall : req_low;
	// level request negated gets no ack
	assign detect = (samp_q | arm_now) & req_seen & ~stop_req & ~te_q
		& (count_q != CNT_W'(0)) & ~burst_run_q & (pend_q != 2'h3);

	// single level rearm after cycle start
	// dual level rearm after write start
	assign arm_late = (cfg.single & ~cfg.edge_det & (state_q == dma_req_pkg::ST_RD)
		& bus_cycle_start)
		| (~cfg.single & ~cfg.edge_det & (state_q == dma_req_pkg::ST_WR) & bus_cycle_start)
		| (cfg.single & cfg.edge_det & ~cfg.burst & ack_q)
		| ((state_q == dma_req_pkg::ST_IDLE) & (pend_q == 2'h0) & ~burst_run_q);
	// dual edge resamples as read ends
	assign arm_now = ~cfg.single & cfg.edge_det & ~cfg.burst
		& (state_q == dma_req_pkg::ST_RD) & bus_cycle_end;

	// burst edge sampled once, then held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samp_q <= 1'b1;
			burst_run_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			if (detect) begin
				samp_q <= 1'b0;
			end else if (arm_late) begin
				samp_q <= 1'b1;
			end
			ack_q <= detect;
			if (unit_end && last_unit) begin
				burst_run_q <= 1'b0;
			end else if (unit_end && stop_req) begin
				burst_run_q <= 1'b0;
			end else if (detect && cfg.burst && cfg.edge_det) begin
				burst_run_q <= 1'b1;
			end
		end
	end
	assign request_ack = ack_q;

	// Accepted requests not yet started
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 2'h0;
		end else if (unit_end && last_unit) begin
			pend_q <= 2'h0;
		end else if (detect && !go_wait) begin
			pend_q <= pend_q + 2'h1;
		end else if (go_wait && !detect) begin
			pend_q <= pend_q - 2'h1;
		end
	end

	assign dly_val = cfg.blk32
		? dma_req_pkg::DLY_W'(dma_req_pkg::BLK_START_CYC - dma_req_pkg::LVL_RECOG_CYC - 1)
		: cfg.edge_det
		? dma_req_pkg::DLY_W'(dma_req_pkg::EDGE_START_CYC - dma_req_pkg::EDGE_RECOG_CYC - 1)
		: dma_req_pkg::DLY_W'(dma_req_pkg::LVL_START_CYC - dma_req_pkg::LVL_RECOG_CYC - 1);
	assign go_wait = (state_q == dma_req_pkg::ST_IDLE) & (pend_q != 2'h0);

	start_delay #(.W(dma_req_pkg::DLY_W)) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(go_wait),
		.load_val(dly_val),
		.done(dly_done)
	);

	// cycle length owned by bus controller
	assign unit_end = bus_cycle_end & cyc_on_q
		& ((state_q == dma_req_pkg::ST_WR) | (cfg.single & (state_q == dma_req_pkg::ST_RD)));
	assign last_unit = (count_q == CNT_W'(1));
	// burst edge stop checked per unit
	assign continue_burst = burst_run_q & ~last_unit & ~stop_req;

	always_comb begin
		state_d = state_q;
		case (state_q)
			dma_req_pkg::ST_IDLE: begin
				if (go_wait) begin
					state_d = dma_req_pkg::ST_WAIT;
				end
			end
			dma_req_pkg::ST_WAIT: begin
				if (dly_done) begin
					state_d = dma_req_pkg::ST_RD;
				end
			end
			dma_req_pkg::ST_RD: begin
				if (bus_cycle_end && cyc_on_q) begin
					if (!cfg.single) begin
						state_d = dma_req_pkg::ST_WR;
					end else if (continue_burst) begin
						state_d = dma_req_pkg::ST_RD;
					end else begin
						state_d = dma_req_pkg::ST_IDLE;
					end
				end
			end
			dma_req_pkg::ST_WR: begin
				if (unit_end) begin
					state_d = continue_burst ? dma_req_pkg::ST_RD : dma_req_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = dma_req_pkg::ST_IDLE;
			end
		endcase
	end

	// Bus cycle request and data acknowledge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= dma_req_pkg::ST_IDLE;
			breq_q <= 1'b0;
			cyc_on_q <= 1'b0;
			data_ack_q <= 1'b0;
			since_det_q <= 3'h0;
		end else begin
			state_q <= state_d;
			if (bus_cycle_start) begin
				breq_q <= 1'b0;
			end else if ((state_d == dma_req_pkg::ST_RD || state_d == dma_req_pkg::ST_WR)
				&& (state_d != state_q || bus_cycle_end)) begin
				breq_q <= 1'b1;
			end
			if (bus_cycle_start) begin
				cyc_on_q <= 1'b1;
			end else if (bus_cycle_end) begin
				cyc_on_q <= 1'b0;
			end
			// dual cycle picked by placement bit
			data_ack_q <= (bus_cycle_start | (cyc_on_q & ~bus_cycle_end))
				& (cfg.single | (state_d == (cfg.ack_wr ? dma_req_pkg::ST_WR
				: dma_req_pkg::ST_RD)));
			if (detect) begin
				since_det_q <= 3'h0;
			end else if (since_det_q != 3'h7) begin
				since_det_q <= since_det_q + 3'h1;
			end
		end
	end
	assign bus_cycle_req = breq_q;
	assign bus_cycle_wr = (state_q == dma_req_pkg::ST_WR);
	assign data_ack = data_ack_q;

	ack_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		request_ack |=> !request_ack) else $error("ack held over one cycle");
	start_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == dma_req_pkg::ST_WAIT) && (state_d == dma_req_pkg::ST_RD) && !cfg.edge_det
		|-> since_det_q >= 3'h2) else $error("bus cycle too early");
	burst_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
		burst_run_q |=> !request_ack) else $error("burst edge acked again");
	stop_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_req |=> !request_ack) else $error("request taken while stopping");
	data_ack_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg.single && bus_cycle_start && $stable(cfg) |=> data_ack) else $error("no data ack");
	te_last_a: assert property (@(posedge aclk) disable iff (!aresetn)
		unit_end && last_unit |=> te_q && (count_q == CNT_W'(0))) else $error("end flag missed");
	breq_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		bus_cycle_req && !bus_cycle_start |=> bus_cycle_req) else $error("bus request dropped");
	data_ack_dual_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg.single && data_ack && $stable(cfg) |-> $past(state_d) == (cfg.ack_wr
		? dma_req_pkg::ST_WR : dma_req_pkg::ST_RD)) else $error("data ack in wrong cycle");
endmodule : dma_req_handshake
`default_nettype wire

// File: verilog/dma_req_pkg.sv
/*
 * Constants, register layout and carrier types of the external request
 * handshake block of one DMA channel.
 * Assumes a 32-bit AXI4-Lite register bus and one bus clock.
 */
`default_nettype none
package dma_req_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_OPER = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] COUNT_RST = 32'h00000000;
	localparam logic [31:0] OPER_RST = 32'h00000000;
	// channel_control field positions
	localparam int CTL_EN = 0;
	localparam int CTL_BURST = 1;
	localparam int CTL_SINGLE = 2;
	localparam int CTL_EDGE = 3;
	localparam int CTL_ACKWR = 4;
	localparam int CTL_IE = 5;
	localparam int CTL_BLK32 = 6;
	localparam int CTL_TE = 8;
	localparam int CFG_W = 7;
	// dma_operation_ctrl field position
	localparam int OPR_ME = 0;
	// Recognition and earliest start, in bus clock cycles from the sample
	localparam int LVL_RECOG_CYC = 1;
	localparam int EDGE_RECOG_CYC = 2;
	localparam int LVL_START_CYC = 4;
	localparam int EDGE_START_CYC = 5;
	localparam int BLK_START_CYC = 6;
	localparam int DLY_W = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef struct packed {
		logic blk32;
		logic ie;
		logic ack_wr;
		logic edge_det;
		logic single;
		logic burst;
		logic enable;
	} cfg_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT = 3'h1,
		ST_RD = 3'h3,
		ST_WR = 3'h2
	} state_e;
endpackage : dma_req_pkg
`default_nettype wire

// File: verilog/req_sync.sv
/*
 * Three-stage synchroniser for the active-low request pin with level and
 * falling-edge outputs.
 * Assumes the pin is asynchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module req_sync (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin side
	input wire logic xfer_request_n,
	// Recognised request
	output logic req_low,
	output logic req_fall
);
	logic s1_q, s2_q, s3_q, stable_q, prev_q, fall_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			stable_q <= 1'b1;
			prev_q <= 1'b1;
			fall_q <= 1'b0;
		end else begin
			s1_q <= xfer_request_n;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				stable_q <= s3_q;
			end
			// Edge seen one cycle after the level
			prev_q <= stable_q;
			fall_q <= prev_q & ~stable_q;
		end
	end
	assign req_low = ~stable_q;
	assign req_fall = fall_q;
	edge_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
		req_fall |-> !stable_q && !$past(stable_q) && $past(stable_q, 2))
		else $error("edge not one cycle late");
endmodule : req_sync
`default_nettype wire

// File: verilog/start_delay.sv
/*
 * Down counter that holds off the first bus cycle after a recognised request.
 * Assumes load is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module start_delay #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// Status
	output logic done
);
	logic [W-1:0] cnt_q;
	logic run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= load_val;
			run_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q - W'(1);
			run_q <= (cnt_q > W'(1));
		end
	end
	assign done = run_q & (cnt_q <= W'(1));
endmodule : start_delay
`default_nettype wire
